// ==== qaw_top.sv ====
// q&a watchdog answer evaluation: apb registers, window sequencer, failure counter
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module qaw_top #(
  parameter int FAIL_W = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status out
  output logic [FAIL_W-1:0] fail_count,
  output logic irq
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic enable;
    logic single;
    logic [15:0] win1;
    logic [15:0] second_response_window;
    logic [15:0] tmr;
    qaw_pkg::qaw_phase_t phase;
    logic [3:0] result;
    logic [FAIL_W-1:0] fail;
    logic [qaw_pkg::IRQ_BITS-1:0] ist;
    logic [qaw_pkg::IRQ_BITS-1:0] ien;
    logic irq;
    logic ans_valid;
    logic ans_correct;
    logic start;
    logic open_good;
    logic any_answer;
  } qaw_st_t;
  qaw_st_t s_q, s_d;
  qaw_eval_if ev ();
  qaw_eval u_eval (
    .mclk(mclk),
    .rst(rst),
    .ev(ev)
  );
  assign ev.ans_valid = s_q.ans_valid;
  assign ev.ans_correct = s_q.ans_correct;
  assign ev.in_closed = (s_q.phase == qaw_pkg::QAW_CLOSED);
  assign ev.in_open = (s_q.phase == qaw_pkg::QAW_OPEN);
  assign ev.single_mode = s_q.single;
  assign ev.cycle_start = s_q.start;
  function automatic logic [FAIL_W-1:0] sat_step(input logic [FAIL_W-1:0] v, input logic up);
    logic [FAIL_W-1:0] r;
    r = v;
    if (up && v != {FAIL_W{1'b1}})
      r = v + 1'b1;
    else if (!up && v != '0)
      r = v - 1'b1;
    return r;
  endfunction
  logic access;
  logic wr;
  logic rd;
  logic [3:0] end_flags;
  logic cycle_done;
  logic inc;
  logic dec;
  always_comb
  begin
    s_d = s_q;
    access = psel && penable;
    wr = access && pwrite;
    rd = access && !pwrite;
    s_d.pready = access && !s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata = '0;
    s_d.ans_valid = 1'b0;
    s_d.start = 1'b0;
    end_flags = '0;
    cycle_done = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    // window sequencer
    case (s_q.phase)
      qaw_pkg::QAW_IDLE:
      begin
        if (s_q.enable)
        begin
          s_d.phase = qaw_pkg::QAW_CLOSED;
          s_d.tmr = s_q.win1;
          s_d.start = 1'b1;
          s_d.open_good = 1'b0;
          s_d.any_answer = 1'b0;
        end
      end
      qaw_pkg::QAW_CLOSED:
      begin
        if (ev.cycle_end)
        begin
          end_flags = ev.flags;
          cycle_done = 1'b1;
          inc = ev.fail_inc;
        end
        else if (s_q.tmr == '0)
        begin
          s_d.phase = qaw_pkg::QAW_OPEN;
          s_d.tmr = s_q.second_response_window;
        end
        else
          s_d.tmr = s_q.tmr - 16'h1;
      end
      default:
      begin
        if (s_q.ans_valid)
        begin
          s_d.any_answer = 1'b1;
          s_d.open_good = s_q.ans_correct && !s_q.any_answer;
        end
        if (s_q.tmr == '0)
        begin
          cycle_done = 1'b1;
          if (!s_q.any_answer)
          begin
            end_flags[qaw_pkg::RES_TIMEOUT] = 1'b1;
            inc = 1'b1;
          end
          else if (s_q.open_good)
            dec = 1'b1;
          else
          begin
            end_flags[qaw_pkg::RES_WRONG] = 1'b1;
            inc = 1'b1;
          end
        end
        else
          s_d.tmr = s_q.tmr - 16'h1;
      end
    endcase
    if (s_q.phase == qaw_pkg::QAW_CLOSED && s_q.ans_valid)
      s_d.any_answer = 1'b1;
    if (cycle_done)
    begin
      // same question is reused; the next cycle starts after one clock in QAW_IDLE
      s_d.phase = qaw_pkg::QAW_IDLE;
      s_d.ist[qaw_pkg::IRQ_CYCLE] = 1'b1;
      if (inc)
        s_d.ist[qaw_pkg::IRQ_FAIL] = 1'b1;
      if (dec)
        s_d.ist[qaw_pkg::IRQ_FAIL_DEC] = 1'b1;
      if (inc || dec)
        s_d.fail = sat_step(s_q.fail, inc);
    end
    if (!s_q.enable)
      s_d.phase = qaw_pkg::QAW_IDLE;
    // register access on the first access cycle only
    if (rd && !s_q.pready)
    begin
      if (paddr == qaw_pkg::ADDR_RESULT)
      begin
        s_d.prdata[3:0] = s_q.result;
        s_d.result = '0;
      end
      else if (paddr == qaw_pkg::ADDR_CTRL)
      begin
        s_d.prdata[qaw_pkg::CTRL_ENABLE] = s_q.enable;
        s_d.prdata[qaw_pkg::CTRL_SINGLE] = s_q.single;
      end
      else if (paddr == qaw_pkg::ADDR_FAIL)
        s_d.prdata[FAIL_W-1:0] = s_q.fail;
      else if (paddr == qaw_pkg::ADDR_IRQ_STAT)
        s_d.prdata[qaw_pkg::IRQ_BITS-1:0] = s_q.ist;
      else if (paddr == qaw_pkg::ADDR_IRQ_EN)
        s_d.prdata[qaw_pkg::IRQ_BITS-1:0] = s_q.ien;
      else if (paddr == qaw_pkg::ADDR_WIN1)
        s_d.prdata[15:0] = s_q.win1;
      else if (paddr == qaw_pkg::ADDR_SECOND_RESPONSE_WINDOW)
        s_d.prdata[15:0] = s_q.second_response_window;
      else if (paddr == qaw_pkg::ADDR_ANSWER || paddr == qaw_pkg::ADDR_IRQ_CLR)
        s_d.prdata = '0;
      else
        s_d.pslverr = 1'b1;
    end
    if (wr && !s_q.pready)
    begin
      if (paddr == qaw_pkg::ADDR_CTRL)
      begin
        s_d.enable = pwdata[qaw_pkg::CTRL_ENABLE];
        s_d.single = pwdata[qaw_pkg::CTRL_SINGLE];
      end
      else if (paddr == qaw_pkg::ADDR_ANSWER)
      begin
        s_d.ans_valid = 1'b1;
        s_d.ans_correct = pwdata[qaw_pkg::ANS_CORRECT];
      end
      else if (paddr == qaw_pkg::ADDR_IRQ_EN)
        s_d.ien = pwdata[qaw_pkg::IRQ_BITS-1:0];
      else if (paddr == qaw_pkg::ADDR_IRQ_CLR)
        s_d.ist = s_q.ist & ~pwdata[qaw_pkg::IRQ_BITS-1:0];
      else if (paddr == qaw_pkg::ADDR_WIN1)
        s_d.win1 = pwdata[15:0];
      else if (paddr == qaw_pkg::ADDR_SECOND_RESPONSE_WINDOW)
        s_d.second_response_window = pwdata[15:0];
      else if (paddr == qaw_pkg::ADDR_RESULT || paddr == qaw_pkg::ADDR_FAIL
               || paddr == qaw_pkg::ADDR_IRQ_STAT)
        s_d.pslverr = 1'b0;
      else
        s_d.pslverr = 1'b1;
    end
    // a cycle end beats a clearing read or clear write in the same clock
    if (cycle_done)
    begin
      s_d.result = end_flags;
      s_d.ist[qaw_pkg::IRQ_CYCLE] = 1'b1;
      if (inc)
        s_d.ist[qaw_pkg::IRQ_FAIL] = 1'b1;
      if (dec)
        s_d.ist[qaw_pkg::IRQ_FAIL_DEC] = 1'b1;
    end
    s_d.irq = |(s_d.ist & s_d.ien);
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.fail <= FAIL_W'(qaw_pkg::FAIL_RESET);
      s_q.win1 <= qaw_pkg::WIN1_RESET;
      s_q.second_response_window <= qaw_pkg::SECOND_RESPONSE_WINDOW_RESET;
      s_q.single <= 1'b1;
      s_q.phase <= qaw_pkg::QAW_IDLE;
    end
    else
      s_q <= s_d;
  end
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign fail_count = s_q.fail;
  assign irq = s_q.irq;
endmodule
`default_nettype wire

// ==== qaw_pkg.sv ====
// package for the q&a watchdog answer evaluation block
package qaw_pkg;
  localparam logic [11:0] ADDR_RESULT = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_ANSWER = 12'h008;
  localparam logic [11:0] ADDR_FAIL = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h014;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h018;
  localparam logic [11:0] ADDR_WIN1 = 12'h01c;
  localparam logic [11:0] ADDR_SECOND_RESPONSE_WINDOW = 12'h020;
  // result register bit positions
  localparam int RES_WRONG = 0;
  localparam int RES_EARLY = 1;
  localparam int RES_SEQ = 2;
  localparam int RES_TIMEOUT = 3;
  // control register bit positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SINGLE = 1;
  // answer register bit position of the correctness bit
  localparam int ANS_CORRECT = 0;
  localparam logic [3:0] FAIL_RESET = 4'h5;
  localparam logic [15:0] WIN1_RESET = 16'h0040;
  localparam logic [15:0] SECOND_RESPONSE_WINDOW_RESET = 16'h0040;
  localparam logic [2:0] MULTI_ANSWERS = 3'h4;
  localparam int IRQ_BITS = 3;
  localparam int IRQ_CYCLE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_FAIL_DEC = 2;
  typedef enum logic [1:0] {QAW_IDLE, QAW_CLOSED, QAW_OPEN} qaw_phase_t;
endpackage

// ==== qaw_eval_if.sv ====
// interface between the cycle sequencer and the evaluator
`timescale 1ns/1ps
`default_nettype none
interface qaw_eval_if;
  logic ans_valid;
  logic ans_correct;
  logic in_closed;
  logic in_open;
  logic single_mode;
  logic cycle_start;
  logic cycle_end;
  logic end_early;
  logic [3:0] flags;
  logic fail_inc;
  logic fail_dec;
  modport seq (output ans_valid, ans_correct, in_closed, in_open, single_mode, cycle_start,
    input cycle_end, end_early, flags, fail_inc, fail_dec);
  modport eval (input ans_valid, ans_correct, in_closed, in_open, single_mode, cycle_start,
    output cycle_end, end_early, flags, fail_inc, fail_dec);
endinterface
`default_nettype wire

// ==== qaw_eval.sv ====
// answer classifier for one watchdog cycle
`timescale 1ns/1ps
`default_nettype none
module qaw_eval (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sequencer side
  qaw_eval_if.eval ev
);
  typedef struct packed {
    logic [2:0] cnt;
    logic closed_any;
    logic closed_bad;
    logic open_good;
    logic open_bad;
    logic seq_bad;
    logic cycle_end;
    logic end_early;
    logic [3:0] flags;
    logic fail_inc;
    logic fail_dec;
  } qaw_eval_st_t;
  qaw_eval_st_t s_q, s_d;
  logic [2:0] need;
  logic window_over;
  always_comb
  begin
    s_d = s_q;
    s_d.cycle_end = 1'b0;
    s_d.end_early = 1'b0;
    s_d.fail_inc = 1'b0;
    s_d.fail_dec = 1'b0;
    need = ev.single_mode ? 3'h1 : qaw_pkg::MULTI_ANSWERS;
    window_over = 1'b0;
    if (ev.cycle_start)
    begin
      s_d.cnt = '0;
      s_d.closed_any = 1'b0;
      s_d.closed_bad = 1'b0;
      s_d.open_good = 1'b0;
      s_d.open_bad = 1'b0;
      s_d.seq_bad = 1'b0;
    end
    else if (ev.ans_valid && (ev.in_closed || ev.in_open))
    begin
      s_d.cnt = s_q.cnt + 3'h1;
      if (s_q.cnt >= need)
        s_d.seq_bad = 1'b1;
      if (ev.in_closed)
      begin
        s_d.closed_any = 1'b1;
        s_d.closed_bad = s_q.closed_bad | ~ev.ans_correct;
      end
      else if (ev.ans_correct)
        s_d.open_good = 1'b1;
      else
        s_d.open_bad = 1'b1;
      // cycle closes early once the closed window got its full answer set
      if (ev.in_closed && (s_q.cnt + 3'h1 == need))
        window_over = 1'b1;
    end
    // flags only latch as a cycle ends, never per answer
    if (window_over)
    begin
      s_d.cycle_end = 1'b1;
      s_d.end_early = 1'b1;
      s_d.flags = '0;
      s_d.flags[qaw_pkg::RES_WRONG] = s_d.closed_bad;
      s_d.flags[qaw_pkg::RES_EARLY] = 1'b1;
      s_d.fail_inc = 1'b1;
    end
  end
  // end of the second window is judged by the sequencer, not here
  always_ff @(posedge mclk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign ev.cycle_end = s_q.cycle_end;
  assign ev.end_early = s_q.end_early;
  assign ev.flags = s_q.flags;
  assign ev.fail_inc = s_q.fail_inc;
  assign ev.fail_dec = s_q.fail_dec;
endmodule
`default_nettype wire

// ==== qaw_top_sva.sv ====
// port assertions for the watchdog answer evaluation block
`timescale 1ns/1ps
`default_nettype none
module qaw_top_sva #(
  parameter int FAIL_W = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // status
  input wire logic [FAIL_W-1:0] fail_count,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_after_access: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  a_ready_wait_state: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (pready && paddr > 12'h020 |-> pslverr)
    else $error("unmapped access not refused");
  a_fail_step_one: assert property ($changed(fail_count) |->
    fail_count == $past(fail_count) + 1'b1 || fail_count == $past(fail_count) - 1'b1)
    else $error("failure counter jumped");
  a_fail_floor_hold: assert property (fail_count == '0 |=> fail_count != '1)
    else $error("failure counter wrapped below zero");
  a_fail_top_hold: assert property (fail_count == '1 |=> fail_count != '0)
    else $error("failure counter wrapped above top");
  a_fail_reset_value: assert property ($past(rst) |-> fail_count == FAIL_W'(4'h5))
    else $error("failure counter reset value wrong");
  // irq only drops after a register write
  a_irq_fall_write: assert property ($fell(irq) |->
    $past(psel && pwrite, 1) || $past(psel && pwrite, 2))
    else $error("irq dropped without a write");
endmodule
bind qaw_top qaw_top_sva #(.FAIL_W(FAIL_W)) u_sva (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .fail_count(fail_count), .irq(irq));
`default_nettype wire

// ==== qaw_mcu.sv ====
// controller model answering the watchdog over apb
`timescale 1ns/1ps
`default_nettype none
module qaw_mcu (
  // clock
  input wire logic mclk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus must not look like stale valid data
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the watchdog answer evaluation block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] fcnt;
  logic irq;
  logic [31:0] q;
  logic e;
  int fail_count = 0;
  int total_checks = 0;
  qaw_top #(.FAIL_W(4)) dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fail_count(fcnt), .irq(irq));
  qaw_mcu mcu (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    mcu.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    mcu.xfer(1'b0, a, 32'h00000000, q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // windows are 65 cycles each: answers at +80 land in the open window
  task automatic open_answer;
    wr(qaw_pkg::ADDR_CTRL, 32'h00000003);
    cyc(80);
    wr(qaw_pkg::ADDR_ANSWER, 32'h00000001);
    cyc(70);
  endtask
  task automatic stop;
    wr(qaw_pkg::ADDR_CTRL, 32'h00000002);
  endtask
  task automatic t_reset;
    chk("fail_count", 32'h00000005, 32'(fcnt));
    chk("irq", 32'h00000000, 32'(irq));
    rd(qaw_pkg::ADDR_FAIL);
    chk("fail reg", 32'h00000005, q);
    rd(12'h024);
    chk("pslverr", 32'h00000001, 32'(e));
  endtask
  task automatic t_open_good;
    wr(qaw_pkg::ADDR_IRQ_EN, 32'h00000001);
    open_answer;
    rd(qaw_pkg::ADDR_RESULT);
    chk("result", 32'h00000000, q);
    chk("fail_count", 32'h00000004, 32'(fcnt));
    chk("irq", 32'h00000001, 32'(irq));
    stop;
    wr(qaw_pkg::ADDR_IRQ_EN, 32'h00000000);
    cyc(2);
    chk("irq masked", 32'h00000000, 32'(irq));
    wr(qaw_pkg::ADDR_IRQ_EN, 32'h00000001);
    cyc(2);
    chk("irq unmasked", 32'h00000001, 32'(irq));
    wr(qaw_pkg::ADDR_IRQ_CLR, 32'h00000007);
    cyc(2);
    chk("irq cleared", 32'h00000000, 32'(irq));
  endtask
  task automatic t_timeout;
    wr(qaw_pkg::ADDR_CTRL, 32'h00000003);
    cyc(40);
    rd(qaw_pkg::ADDR_RESULT);
    chk("result mid cycle", 32'h00000000, q);
    cyc(110);
    chk("fail_count", 32'h00000005, 32'(fcnt));
    rd(qaw_pkg::ADDR_RESULT);
    chk("result", 32'h00000008, q);
    rd(qaw_pkg::ADDR_RESULT);
    chk("result reread", 32'h00000000, q);
    stop;
  endtask
  task automatic t_early(input logic [31:0] ans, input logic [31:0] cnt, input logic [31:0] res);
    wr(qaw_pkg::ADDR_CTRL, 32'h00000003);
    wr(qaw_pkg::ADDR_ANSWER, ans);
    cyc(20);
    chk("fail_count", cnt, 32'(fcnt));
    rd(qaw_pkg::ADDR_RESULT);
    chk("result", res, q);
    stop;
  endtask
  task automatic t_multi;
    wr(qaw_pkg::ADDR_CTRL, 32'h00000001);
    wr(qaw_pkg::ADDR_ANSWER, 32'h00000001);
    wr(qaw_pkg::ADDR_ANSWER, 32'h00000000);
    wr(qaw_pkg::ADDR_ANSWER, 32'h00000001);
    chk("fail_count third", 32'h00000007, 32'(fcnt));
    wr(qaw_pkg::ADDR_ANSWER, 32'h00000000);
    cyc(20);
    chk("fail_count fourth", 32'h00000008, 32'(fcnt));
    rd(qaw_pkg::ADDR_RESULT);
    chk("result", 32'h00000003, q);
    stop;
  endtask
  task automatic t_floor;
    repeat (9)
    begin
      open_answer;
      stop;
    end
    chk("fail_count", 32'h00000000, 32'(fcnt));
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_open_good;
    t_timeout;
    t_early(32'h00000001, 32'h00000006, 32'h00000002);
    t_early(32'h00000000, 32'h00000007, 32'h00000003);
    t_multi;
    t_floor;
    wrap_up;
  end
  initial
  begin
    repeat (6000) @(posedge mclk);
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
